// *** hdl/tdm_dma_consts.vh ***
// Purpose: Constants for the TDM serial DMA block
// Assumes: Word-indexed register port, 16-bit data
// Notes: Included by tdm_serial_dma_timing.v
`ifndef TDM_DMA_CONSTS_VH
`define TDM_DMA_CONSTS_VH

// Register word addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define REG_MASK 8'h02
`define REG_COUNTS 8'h03
`define REG_POSITION 8'h04
`define TX_BUF_BASE 4'h1
`define RX_BUF_BASE 4'h2

// Control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_CODECS_LSB 1
`define CTRL_CODECS_MSB 2
`define CTRL_RESET 3'h0

// Status and mask fields
`define STAT_TX_BIT 0
`define STAT_RX_BIT 1
`define STAT_RESET 2'h0
`define MASK_RESET 2'h0

// Frame geometry
`define SLOT_BITS 4'hf
`define LAST_SLOT 4'hf
`define FRAME_LAST_BIT 8'hff
`define BASE_ACTIVE_SLOTS 4'h5
`define SLOTS_PER_CODEC 4'h2
`define PRELOAD_WORDS 4'h2

// Irq delay after slot LSB is received, in core clocks
`define TX_IRQ_DELAY 2

// Initial transmit buffer content
`define TX_TAG_INIT 16'he000
`define TX_ADDR_INIT 16'h7400
`define TX_DATA_INIT 16'hff80
`define TX_FILL_INIT 16'h0000

`endif

// *** hdl/tdm_serial_dma_timing.v ***
// Purpose: Chained TX/RX DMA behind a 16-slot TDM serial port
// Assumes: Bit clock input far slower than i_clk_sys, sampled here
// Notes: Frame sync generated every 256 bit clocks (48 kHz at 12.288 MHz)
`timescale 1ns/100ps
`include "tdm_dma_consts.vh"

module tdm_serial_dma_timing (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  input wire i_bit_clk,
  input wire i_rx_data_line,
  output reg o_tx_data_line,
  output reg o_rx_frame_sync,
  output reg o_irq
);

  integer i;
  integer j;

  reg [15:0] tx_buf_q [0:15];
  reg [15:0] rx_buf_q [0:15];

  reg [2:0] ctrl_q;
  reg [1:0] status_q;
  reg [1:0] status_d;
  reg [1:0] mask_q;

  reg bclk_s1_q;
  reg bclk_s2_q;
  reg bclk_s3_q;
  reg rxd_s1_q;
  reg rxd_s2_q;

  reg [7:0] pos_q;
  reg [15:0] tx_shift_q;
  reg [15:0] tx_hold_register_q;
  reg [15:0] rx_shift_q;
  reg [3:0] tx_dma_count_q;
  reg [3:0] rx_dma_count_q;
  reg [`TX_IRQ_DELAY-1:0] tx_irq_pipe_q;
  reg rx_irq_ev_q;

  wire enable = ctrl_q[`CTRL_ENABLE_BIT];
  wire [1:0] extra_codecs = ctrl_q[`CTRL_CODECS_MSB:`CTRL_CODECS_LSB];
  wire bclk_rise = bclk_s2_q & ~bclk_s3_q;
  wire bclk_fall = ~bclk_s2_q & bclk_s3_q;
  wire [3:0] slot = pos_q[7:4];
  wire [3:0] bit_idx = pos_q[3:0];
  wire [7:0] pos_next = pos_q + 8'h01;
  wire [3:0] slot_next = pos_next[7:4];
  wire [3:0] bit_next = pos_next[3:0];

  // Active slots: five for one codec, two more per chained codec up to two chained codecs (codec field 3 counts as two)
  reg [3:0] active_slots;
  always @*
  begin
    active_slots = `BASE_ACTIVE_SLOTS;
    case (extra_codecs)
      2'h1:
      begin
        active_slots = `BASE_ACTIVE_SLOTS + `SLOTS_PER_CODEC;
      end
      2'h2, 2'h3:
      begin
        active_slots = `BASE_ACTIVE_SLOTS + `SLOTS_PER_CODEC + `SLOTS_PER_CODEC;
      end
      default:
      begin
        active_slots = `BASE_ACTIVE_SLOTS;
      end
    endcase
  end

  wire [3:0] last_active = active_slots - 4'h1;
  wire [3:0] tx_preload_count = active_slots - `PRELOAD_WORDS;
  wire slot_end = bclk_fall & (bit_idx == `SLOT_BITS);
  wire slot_active = slot < active_slots;
  wire next_active = slot_next < active_slots;
  wire [3:0] fetch_idx = slot + 4'h2;

  // Link synchronisers
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
      rxd_s1_q <= 1'b0;
      rxd_s2_q <= 1'b0;
    end
    else
    begin
      bclk_s1_q <= i_bit_clk;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
      rxd_s1_q <= i_rx_data_line;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // Frame position, frame sync and transmit line
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      pos_q <= `FRAME_LAST_BIT;
      o_rx_frame_sync <= 1'b0;
      o_tx_data_line <= 1'b0;
    end
    else if (!enable)
    begin
      pos_q <= `FRAME_LAST_BIT;
      o_rx_frame_sync <= 1'b0;
      o_tx_data_line <= 1'b0;
    end
    else if (bclk_rise)
    begin
      pos_q <= pos_next;
      o_rx_frame_sync <= (slot_next == 4'h0);
      if (next_active)
      begin
        o_tx_data_line <= tx_shift_q[`SLOT_BITS - bit_next];
      end
      else
      begin
        o_tx_data_line <= 1'b0;
      end
    end
  end

  // Transmit DMA: preload, per-slot advance and reload
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      tx_shift_q <= `TX_TAG_INIT;
      tx_hold_register_q <= `TX_ADDR_INIT;
      tx_dma_count_q <= `BASE_ACTIVE_SLOTS - `PRELOAD_WORDS;
    end
    else if (!enable)
    begin
      tx_shift_q <= tx_buf_q[0];
      tx_hold_register_q <= tx_buf_q[1];
      tx_dma_count_q <= tx_preload_count;
    end
    else if (slot_end && slot_active)
    begin
      if (slot == last_active)
      begin
        tx_shift_q <= tx_buf_q[0];
        tx_hold_register_q <= tx_buf_q[1];
        tx_dma_count_q <= tx_preload_count;
      end
      else
      begin
        tx_shift_q <= tx_hold_register_q;
        if (fetch_idx < active_slots)
        begin
          tx_hold_register_q <= tx_buf_q[fetch_idx];
          tx_dma_count_q <= tx_dma_count_q - 4'h1;
        end
      end
    end
  end

  // Receive DMA: shift in, store per active slot, reload at last active slot
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      rx_shift_q <= 16'h0000;
      rx_dma_count_q <= `BASE_ACTIVE_SLOTS;
      for (i = 0; i < 16; i = i + 1)
      begin
        rx_buf_q[i] <= 16'h0000;
      end
    end
    else if (!enable)
    begin
      rx_shift_q <= 16'h0000;
      rx_dma_count_q <= active_slots;
    end
    else if (bclk_fall)
    begin
      rx_shift_q <= {rx_shift_q[14:0], rxd_s2_q};
      if (slot_end && slot_active)
      begin
        rx_buf_q[slot] <= {rx_shift_q[14:0], rxd_s2_q};
        if (slot == last_active)
        begin
          rx_dma_count_q <= active_slots;
        end
        else
        begin
          rx_dma_count_q <= rx_dma_count_q - 4'h1;
        end
      end
    end
  end

  // Interrupt events: tx at count zero after delay, rx at last active slot
  wire tx_zero_ev = slot_end && slot_active && (fetch_idx == last_active);
  wire rx_done_ev = slot_end && slot_active && (slot == last_active);

  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      tx_irq_pipe_q <= {`TX_IRQ_DELAY{1'b0}};
      rx_irq_ev_q <= 1'b0;
    end
    else
    begin
      tx_irq_pipe_q <= {tx_irq_pipe_q[`TX_IRQ_DELAY-2:0], tx_zero_ev & enable};
      rx_irq_ev_q <= rx_done_ev & enable;
    end
  end

  wire tx_irq_ev = tx_irq_pipe_q[`TX_IRQ_DELAY-1];

  // Status: set wins over write-one-to-clear
  always @*
  begin
    status_d = status_q;
    if (i_wr && (i_addr == `REG_STATUS))
    begin
      status_d = status_q & ~i_wdata[1:0];
    end
    if (tx_irq_ev)
    begin
      status_d[`STAT_TX_BIT] = 1'b1;
    end
    if (rx_irq_ev_q)
    begin
      status_d[`STAT_RX_BIT] = 1'b1;
    end
  end

  // Register writes
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      ctrl_q <= `CTRL_RESET;
      status_q <= `STAT_RESET;
      mask_q <= `MASK_RESET;
      o_irq <= 1'b0;
      tx_buf_q[0] <= `TX_TAG_INIT;
      tx_buf_q[1] <= `TX_ADDR_INIT;
      tx_buf_q[2] <= `TX_DATA_INIT;
      for (j = 3; j < 16; j = j + 1)
      begin
        tx_buf_q[j] <= `TX_FILL_INIT;
      end
    end
    else
    begin
      status_q <= status_d;
      o_irq <= |(status_d & mask_q);
      if (i_wr)
      begin
        if (i_addr == `REG_CTRL)
        begin
          ctrl_q <= i_wdata[2:0];
        end
        if (i_addr == `REG_MASK)
        begin
          mask_q <= i_wdata[1:0];
        end
        if (i_addr[7:4] == `TX_BUF_BASE)
        begin
          tx_buf_q[i_addr[3:0]] <= i_wdata;
        end
      end
    end
  end

  // Register reads, data in the following cycle
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_rdata <= 16'h0000;
    end
    else if (i_rd)
    begin
      case (i_addr[7:4])
        4'h0:
        begin
          case (i_addr)
            `REG_CTRL:
            begin
              o_rdata <= {13'h0000, ctrl_q};
            end
            `REG_STATUS:
            begin
              o_rdata <= {14'h0000, status_q};
            end
            `REG_MASK:
            begin
              o_rdata <= {14'h0000, mask_q};
            end
            `REG_COUNTS:
            begin
              o_rdata <= {4'h0, rx_dma_count_q, 4'h0, tx_dma_count_q};
            end
            `REG_POSITION:
            begin
              o_rdata <= {8'h00, pos_q};
            end
            default:
            begin
              o_rdata <= 16'h0000;
            end
          endcase
        end
        `TX_BUF_BASE:
        begin
          o_rdata <= tx_buf_q[i_addr[3:0]];
        end
        `RX_BUF_BASE:
        begin
          o_rdata <= rx_buf_q[i_addr[3:0]];
        end
        default:
        begin
          o_rdata <= 16'h0000;
        end
      endcase
    end
    else
    begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// *** test/tdm_dma_checker_assertions.sv ***
// Purpose: Port checks of the TDM DMA block
// Assumes: Bit clock of exactly 8 core clocks
// Notes: Mirrors ctrl and mask writes
`timescale 1ns/100ps
module tdm_dma_checker (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire o_tx_data_line,
  input wire o_rx_frame_sync,
  input wire o_irq
);
  reg [2:0] ctl_q;
  reg [1:0] msk_q;
  reg [11:0] fc_q;
  reg fs_q;
  reg seen_q;
  // Clocks of all active slots
  wire [11:0] act = 12'd640 + (ctl_q[2] ? 12'd512 : {3'h0, ctl_q[1], 8'h00});
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  always @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      ctl_q <= 3'h0;
      msk_q <= 2'h0;
      fc_q <= 12'h000;
      fs_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == 8'h00)
        ctl_q <= i_wdata[2:0];
      if (i_wr && i_addr == 8'h02)
        msk_q <= i_wdata[1:0];
      fs_q <= o_rx_frame_sync;
      fc_q <= (o_rx_frame_sync && !fs_q) ? 12'h000 : fc_q + {11'h0, fc_q != 12'hfff};
      seen_q <= ctl_q[0] && (seen_q || o_rx_frame_sync);
    end
  end
  sequence s_fs_fall;
    o_rx_frame_sync ##1 !o_rx_frame_sync && ctl_q[0];
  endsequence
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 16'h0000;
  endproperty
  property p_rst_out;
    $rose(i_resetn) |-> !o_irq && !o_rx_frame_sync && !o_tx_data_line;
  endproperty
  property p_off_quiet;
    !$past(ctl_q[0]) && !$past(ctl_q[0], 2) |-> !o_tx_data_line && !o_rx_frame_sync;
  endproperty
  property p_fs_len;
    s_fs_fall |-> fc_q inside {[12'd126:12'd129]};
  endproperty
  property p_frame;
    o_rx_frame_sync && !fs_q && seen_q |-> fc_q inside {[12'd2046:12'd2048]};
  endproperty
  property p_tx_quiet;
    seen_q && fc_q >= act + 12'd8 && fc_q < 12'd2040 |-> !o_tx_data_line;
  endproperty
  property p_tx_irq;
    $rose(o_irq) && msk_q == 2'h1 && $past(msk_q, 2) == 2'h1 && seen_q
      |-> fc_q + 12'd264 >= act && fc_q + 12'd240 <= act;
  endproperty
  property p_rx_irq;
    $rose(o_irq) && msk_q == 2'h2 && $past(msk_q, 2) == 2'h2 && seen_q
      |-> fc_q + 12'd8 >= act && fc_q <= act + 12'd16;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle");
  a_rst_out: assert property (p_rst_out)
    else $error("outputs active after reset");
  a_off_quiet: assert property (p_off_quiet)
    else $error("link active while disabled");
  a_fs_len: assert property (p_fs_len)
    else $error("frame sync length");
  a_frame: assert property (p_frame)
    else $error("frame period");
  a_tx_quiet: assert property (p_tx_quiet)
    else $error("data in idle slot");
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit irq timing");
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive irq timing");
endmodule
bind tdm_serial_dma_timing tdm_dma_checker chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_tx_data_line(o_tx_data_line), .o_rx_frame_sync(o_rx_frame_sync), .o_irq(o_irq));

// *** test/codec_model.sv ***
// Purpose: Codec side of the TDM link
// Assumes: Bit clock runs while i_run is high
// Notes: Each sampled transmit bit returns one bit later
`timescale 1ns/100ps
module codec_model (
  input wire i_run,
  input wire i_tx_data_line,
  output reg o_bit_clk,
  output wire o_rx_data_line,
  output reg [15:0] o_word
);
  assign o_rx_data_line = o_word[0];
  initial
  begin
    o_bit_clk = 1'b0;
    o_word = 16'h0000;
    #13;
    forever
    begin
      #160 o_bit_clk = i_run && !o_bit_clk;
    end
  end
  // Transmit bit is settled at the next rise
  always @(posedge o_bit_clk)
    o_word <= {o_word[14:0], i_tx_data_line};
endmodule

// *** test/tdm_serial_dma_timing_bench.sv ***
// Purpose: Self-checking bench of the TDM DMA block
// Assumes: Codec model loops transmit data back
// Notes: Bit clock 320 ns, core clock 40 ns
`timescale 1ns/100ps
module tdm_serial_dma_timing_bench;
  reg i_clk_sys = 1'b0;
  reg i_resetn = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [15:0] i_wdata = 16'h0000;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg run = 1'b0;
  wire [15:0] o_rdata;
  wire bit_clk;
  wire rx_line;
  wire o_tx_data_line;
  wire o_rx_frame_sync;
  wire o_irq;
  wire [15:0] word;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [15:0] v;
  tdm_serial_dma_timing dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bit_clk(bit_clk),
    .i_rx_data_line(rx_line), .o_tx_data_line(o_tx_data_line),
    .o_rx_frame_sync(o_rx_frame_sync), .o_irq(o_irq));
  codec_model codec (.i_run(run), .i_tx_data_line(o_tx_data_line), .o_bit_clk(bit_clk),
    .o_rx_data_line(rx_line), .o_word(word));
  initial
  begin
    forever
    begin
      #20 i_clk_sys = ~i_clk_sys;
    end
  end
  task results;
  begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
  begin
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  end
  endtask
  task wr(input [7:0] a, input [15:0] d);
  begin
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  end
  endtask
  task rc(input string nm, input [7:0] a, input [15:0] e);
  begin
    rd(a);
    chk(nm, e, v);
  end
  endtask
  // Polls the position register until a bit position is reached
  task wait_pos(input [7:0] p);
    int n;
  begin
    n = 0;
    v = 16'hffff;
    while (v[7:0] !== p && n < 3000)
    begin
      rd(8'h04);
      n++;
    end
    if (n == 3000)
      chk("position", {8'h00, p}, v);
  end
  endtask
  task reset_values;
  begin
    rc("ctrl", 8'h00, 16'h0000);
    rc("stat", 8'h01, 16'h0000);
    rc("mask", 8'h02, 16'h0000);
    rc("txbuf", 8'h10, 16'he000);
    rc("txbuf", 8'h11, 16'h7400);
    rc("txbuf", 8'h12, 16'hff80);
    rc("txbuf", 8'h13, 16'h0000);
    rc("unmapped", 8'h7f, 16'h0000);
  end
  endtask
  task first_frame;
    logic [15:0] tx_e [6] = '{16'he000, 16'h7400, 16'hff80, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] cnt_e [7] = '{16'h0503, 16'h0402, 16'h0301, 16'h0200, 16'h0100, 16'h0503,
      16'h0503};
  begin
    wr(8'h02, 16'h0001);
    run <= 1'b1;
    wr(8'h00, 16'h0001);
    for (int k = 0; k < 7; k++)
    begin
      wait_pos(8'(16 * k));
      chk("fsync", {15'h0, k == 0}, {15'h0, o_rx_frame_sync});
      if (k > 0)
        chk("word", tx_e[k - 1], word);
      rc("counts", 8'h03, cnt_e[k]);
      if (k == 4)
      begin
        rc("stat", 8'h01, 16'h0001);
        chk("irq", 16'h0001, {15'h0, o_irq});
      end
    end
    rc("stat", 8'h01, 16'h0003);
    rc("rxbuf", 8'h20, 16'h7000);
    rc("rxbuf", 8'h21, 16'h3a00);
    rc("rxbuf", 8'h22, 16'h7fc0);
    wr(8'h01, 16'h0003);
    rc("stat", 8'h01, 16'h0000);
    chk("irq", 16'h0000, {15'h0, o_irq});
  end
  endtask
  // Writes to buffer word 0 after reload reach the wire only a frame later, word 3 in the same frame
  task hold_reload;
  begin
    wr(8'h10, 16'h1111);
    wr(8'h13, 16'ha5a5);
    wr(8'h02, 16'h0002);
    wait_pos(8'h10);
    chk("word", 16'he000, word);
    wait_pos(8'h40);
    chk("word", 16'ha5a5, word);
    chk("irq", 16'h0000, {15'h0, o_irq});
    wait_pos(8'h60);
    chk("irq", 16'h0001, {15'h0, o_irq});
    rc("rxbuf", 8'h20, 16'h7000);
    if (v[12])
    begin
      rc("rxbuf", 8'h23, 16'h52d2);
    end
    rc("rxbuf", 8'h24, 16'h8000);
    wait_pos(8'h10);
    chk("word", 16'h1111, word);
  end
  endtask
  task two_codecs;
  begin
    wr(8'h00, 16'h0002);
    wr(8'h00, 16'h0003);
    wait_pos(8'h00);
    rc("counts", 8'h03, 16'h0705);
    wait_pos(8'h30);
    rc("counts", 8'h03, 16'h0402);
    wait_pos(8'h70);
    rc("counts", 8'h03, 16'h0705);
    wr(8'h00, 16'h0004);
    wr(8'h00, 16'h0005);
    wait_pos(8'h00);
    rc("counts", 8'h03, 16'h0907);
    wait_pos(8'h90);
    rc("counts", 8'h03, 16'h0907);
  end
  endtask
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    reset_values;
    first_frame;
    hold_reload;
    two_codecs;
    results;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      results;
    end
  end
endmodule
